/* tb/host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input wire logic ref_clk,
   output logic xfer_start,
   output logic [7:0] reg_ptr,
   output logic wr_stb,
   output logic [7:0] wr_byte,
   output logic rd_stb,
   input wire logic [7:0] rd_byte
);
   initial begin
      xfer_start = 1'b0;
      reg_ptr = 8'h00;
      wr_stb = 1'b0;
      wr_byte = 8'h00;
      rd_stb = 1'b0;
   end

   task automatic open_xfer(input logic [7:0] ptr);
      @(posedge ref_clk) #1;
      xfer_start = 1'b1;
      reg_ptr = ptr;
      @(posedge ref_clk) #1;
      xfer_start = 1'b0;
   endtask : open_xfer

   task automatic write_word(input logic [7:0] ptr, input logic [15:0] w);
      open_xfer(ptr);
      wr_stb = 1'b1;
      wr_byte = w[15:8];
      @(posedge ref_clk) #1;
      wr_byte = w[7:0];
      @(posedge ref_clk) #1;
      wr_stb = 1'b0;
      // Released data must not look like a held byte
      wr_byte = ~w[7:0];
   endtask : write_word

   task automatic read_word(input logic [7:0] ptr, output logic [15:0] w);
      open_xfer(ptr);
      rd_stb = 1'b1;
      @(posedge ref_clk) #1;
      w[15:8] = rd_byte;
      @(posedge ref_clk) #1;
      w[7:0] = rd_byte;
      rd_stb = 1'b0;
   endtask : read_word
endmodule : host_model
`default_nettype wire

/* tb/shunt_bus_conversion_control_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module shunt_bus_checker
   import shunt_bus_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic xfer_start,
   input wire logic [7:0] reg_ptr,
   input wire logic wr_stb,
   input wire logic [7:0] wr_byte,
   input wire logic rd_stb,
   input wire logic [7:0] rd_byte,
   input wire logic signed [15:0] shunt_drop_voltage,
   input wire logic [14:0] supply_rail_voltage,
   input wire logic adc_active,
   input wire logic adc_bus_sel,
   input wire logic conv_done
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // ====
   // Byte port
   sequence s_rd_only;
      rd_stb && !xfer_start && !wr_stb;
   endsequence
   property p_unmapped;
      xfer_start && reg_ptr > BUS_ADDR ##1 s_rd_only |=> rd_byte == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped register read not zero");
   property p_cfg_hi;
      xfer_start && reg_ptr == CFG_ADDR ##1 s_rd_only |=> rd_byte[7:4] == 4'h4;
   endproperty
   a_cfg_hi: assert property (p_cfg_hi)
      else $error("configuration top bits not 0100");
   property p_hold;
      !rd_stb && !$past(wr_stb) && !$past(wr_stb, 2) |=> $stable(rd_byte);
   endproperty
   a_hold: assert property (p_hold)
      else $error("read byte changed without a request");
   property p_rst;
      $rose(rst_b) |-> rd_byte == 8'h00 && !adc_active && !conv_done;
   endproperty
   a_rst: assert property (p_rst)
      else $error("outputs not cleared by reset");

   // ====
   // Conversion sequencing
   // The halt flag lands on the first byte, the sequencer drops one edge later
   property p_halt;
      $rose(wr_stb) && !xfer_start && reg_ptr == CFG_ADDR |->
         ##2 !adc_active;
   endproperty
   a_halt: assert property (p_halt)
      else $error("conversion kept running during a write");
   property p_sel;
      adc_bus_sel |-> adc_active;
   endproperty
   a_sel: assert property (p_sel)
      else $error("bus select outside a conversion");
   property p_done;
      conv_done |-> $past(adc_active, 2) && !$past(adc_active);
   endproperty
   a_done: assert property (p_done)
      else $error("done pulse not after a finished run");
   property p_pulse;
      conv_done |=> !conv_done;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("done pulse longer than one cycle");
endmodule : shunt_bus_checker

bind shunt_bus_conversion_control shunt_bus_checker shunt_bus_checker_inst (
   .ref_clk(ref_clk), .rst_b(rst_b), .xfer_start(xfer_start),
   .reg_ptr(reg_ptr), .wr_stb(wr_stb), .wr_byte(wr_byte),
   .rd_stb(rd_stb), .rd_byte(rd_byte),
   .shunt_drop_voltage(shunt_drop_voltage),
   .supply_rail_voltage(supply_rail_voltage), .adc_active(adc_active),
   .adc_bus_sel(adc_bus_sel), .conv_done(conv_done));
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin \
   mismatches++; $display("Error %0t: got %h want %h", $time, act, exp); \
   end end
module tb;
   import shunt_bus_pkg::*;
   localparam cyc_type SHORT_CYC [8] = '{22'h4, 22'h5, 22'h6, 22'h7,
      22'h8, 22'h9, 22'ha, 22'hb};
   logic ref_clk, rst_b, xfer_start, wr_stb, rd_stb;
   logic adc_active, adc_bus_sel, conv_done;
   logic [7:0] reg_ptr, wr_byte, rd_byte;
   logic signed [15:0] shunt;
   logic [14:0] bus;
   int mismatches, cmp_count;
   int n_tbl [8] = '{32'h1, 32'h4, 32'h10, 32'h40, 32'h80, 32'h100,
      32'h200, 32'h400};

   host_model host_model_inst (.ref_clk(ref_clk), .xfer_start(xfer_start),
      .reg_ptr(reg_ptr), .wr_stb(wr_stb), .wr_byte(wr_byte),
      .rd_stb(rd_stb), .rd_byte(rd_byte));
   shunt_bus_conversion_control #(.CONV_CYC(SHORT_CYC))
      shunt_bus_conversion_control_inst (.ref_clk(ref_clk), .rst_b(rst_b),
      .xfer_start(xfer_start), .reg_ptr(reg_ptr), .wr_stb(wr_stb),
      .wr_byte(wr_byte), .rd_stb(rd_stb), .rd_byte(rd_byte),
      .shunt_drop_voltage(shunt), .supply_rail_voltage(bus),
      .adc_active(adc_active), .adc_bus_sel(adc_bus_sel),
      .conv_done(conv_done));

   task automatic check_reg(input logic [7:0] ptr, input logic [15:0] exp);
      logic [15:0] w;
      host_model_inst.read_word(ptr, w);
      `CHK(w, exp)
   endtask : check_reg

   // Counts done pulses, bus starts and shunt cycles; in averaging runs
   // the inputs step after the first sample so a mean of four or more samples differs from both
   task automatic watch(input int cyc, input logic avg, output int d,
      output int r, output int s);
      logic prev;
      prev = adc_bus_sel;
      d = 0;
      r = 0;
      s = 0;
      repeat (cyc) begin
         @(posedge ref_clk) #1;
         if (adc_bus_sel && !prev) r++;
         if (adc_active && !adc_bus_sel) s++;
         if (avg && !adc_bus_sel && prev) begin
            shunt = 16'h0002;
            bus = 15'h0004;
         end
         if (conv_done === 1'b1) d++;
         prev = adc_bus_sel;
         if (avg && d > 0) break;
      end
   endtask : watch

   task automatic test_reset;
      int d, r, s;
      check_reg(SHUNT_ADDR, RESULT_RESET);
      check_reg(BUS_ADDR, RESULT_RESET);
      check_reg(8'h07, 16'h0000);
      check_reg(CFG_ADDR, CFG_RESET);
      watch(60, 1'b0, d, r, s);
      `CHK(d > 1 && r > 1 && s > 0, 1'b1)
   endtask : test_reset

   task automatic test_modes;
      int d, r, s;
      for (int m = 0; m < 8; m++) begin
         host_model_inst.write_word(CFG_ADDR, 16'h7000 | 16'(m));
         watch(60, 1'b0, d, r, s);
         `CHK(r > 0, m[1] == 1)
         `CHK(s > 0, m[0] == 1)
         `CHK(m[1:0] == 0 ? d == 0 : m[2] ? d > 1 : d == 1, 1'b1)
         check_reg(CFG_ADDR, 16'h4000 | 16'(m));
      end
   endtask : test_modes

   task automatic test_avg;
      int d, r, s;
      for (int c = 0; c < 8; c++) begin
         shunt = 16'hfffe;
         bus = 15'h0000;
         host_model_inst.write_word(CFG_ADDR, 16'(c << AVG_LSB) | 16'h0003);
         watch(30000, 1'b1, d, r, s);
         `CHK(r, n_tbl[c])
         check_reg(SHUNT_ADDR, c == 0 ? 16'hfffe : 16'h0001);
         check_reg(BUS_ADDR, c == 0 ? 16'h0000 : 16'h0003);
         watch(30, 1'b0, d, r, s);
         `CHK(d, 0)
      end
   endtask : test_avg

   task automatic test_soft;
      int d, r, s;
      shunt = 16'h8300;
      bus = 15'h7fff;
      host_model_inst.write_word(CFG_ADDR, 16'h0007);
      watch(40, 1'b0, d, r, s);
      check_reg(SHUNT_ADDR, 16'h8300);
      check_reg(BUS_ADDR, 16'h7fff);
      host_model_inst.write_word(SHUNT_ADDR, 16'h1234);
      check_reg(SHUNT_ADDR, 16'h8300);
      host_model_inst.write_word(BUS_ADDR, 16'h1234);
      check_reg(BUS_ADDR, 16'h7fff);
      host_model_inst.write_word(CFG_ADDR, 16'h8000);
      repeat (3) @(posedge ref_clk);
      check_reg(SHUNT_ADDR, RESULT_RESET);
      check_reg(CFG_ADDR, CFG_RESET);
   endtask : test_soft

   // Shunt code 5 then bus code 2, each in a single triggered run
   task automatic test_times;
      int d, r, s, b;
      host_model_inst.write_word(CFG_ADDR, 16'h00ab);
      watch(60, 1'b0, d, r, s);
      `CHK(s, int'(SHORT_CYC[5]))
      host_model_inst.write_word(CFG_ADDR, 16'h0082);
      b = 0;
      repeat (60) begin
         @(posedge ref_clk) #1;
         if (adc_bus_sel === 1'b1) b++;
      end
      `CHK(b, int'(SHORT_CYC[2]))
   endtask : test_times

   task automatic complete_run;
      $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Whole run is about 17k cycles; the limit leaves ample margin
   initial begin
      #200000;
      mismatches++;
      complete_run();
   end

   initial begin
      rst_b = 1'b0;
      shunt = 16'h0000;
      bus = 15'h0000;
      mismatches = 0;
      cmp_count = 0;
      repeat (12) @(posedge ref_clk);
      #1 rst_b = 1'b1;
      test_reset();
      test_modes();
      test_avg();
      test_soft();
      test_times();
      complete_run();
   end
endmodule : tb
`default_nettype wire

/* verilog/avg_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface avg_link_if;
   logic clear;
   logic add;
   logic signed [15:0] sample;
   logic [3:0] shift;
   logic signed [15:0] result;
   modport ctrl (output clear, output add, output sample, output shift,
      input result);
   modport acc (input clear, input add, input sample, input shift,
      output result);
endinterface : avg_link_if
`default_nettype wire

/* verilog/sample_averager.sv */
`timescale 1ns/10ps
`default_nettype none
module sample_averager
   import shunt_bus_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   avg_link_if.acc lnk
);
   // ==========================================================
   // Accumulator
   logic signed [ACC_W-1:0] acc_r;

   // Clear and add together start a fresh sum from this sample
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         acc_r <= '0;
      end else if (lnk.clear && lnk.add) begin
         acc_r <= ACC_W'(lnk.sample);
      end else if (lnk.clear) begin
         acc_r <= '0;
      end else if (lnk.add) begin
         acc_r <= acc_r + ACC_W'(lnk.sample);
      end
   end

   // Count is a power of two, so the mean is an arithmetic shift
   logic signed [ACC_W-1:0] mean;
   assign mean = acc_r >>> lnk.shift;
   assign lnk.result = mean[15:0];
endmodule : sample_averager
`default_nettype wire

/* verilog/shunt_bus_conversion_control.sv */
// Functional notes
// - Reading the configuration word changes no setting and no conversion.
// - A configuration write halts conversion until done, then restarts.
// - Writing one to configuration bit 15 resets all, and the bit clears.
// - Bits 11:9 choose 1,4,16,64,128,256,512 or 1024 averaged samples.
// - Bits 8:6 choose the bus conversion time, 140 us up to 8.244 ms.
// - Bits 5:3 choose the shunt conversion time with the same table.
// - Bits 2:0: 0/4 power-down, 1-3 triggered, 5-7 continuous.
// - After reset the mode is continuous shunt and bus.
// - The shunt result is a signed 16-bit word of 2.5 uV counts.
// - With averaging, both results show the averaged value.
// - The bus result is an unsigned 15-bit value and bit 15 reads zero.
// - The bus result is read-only and updates only at run completion.
// - The configuration word resets to 4127 hex.
// - Each register moves as two bytes, high byte first.
`timescale 1ns/10ps
`default_nettype none
module shunt_bus_conversion_control
   import shunt_bus_pkg::*;
#(
   parameter cyc_type CONV_CYC [8] = CONV_CYC_TBL
)(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic xfer_start,
   input wire logic [7:0] reg_ptr,
   input wire logic wr_stb,
   input wire logic [7:0] wr_byte,
   input wire logic rd_stb,
   output logic [7:0] rd_byte,
   input wire logic signed [15:0] shunt_drop_voltage,
   input wire logic [14:0] supply_rail_voltage,
   output logic adc_active,
   output logic adc_bus_sel,
   output logic conv_done
);
   // ==========================================================
   // Declarations
   logic soft_rst_r;
   logic rst_all_b;
   logic [15:0] cfg_r;
   logic [15:0] shunt_result_bits_r;
   logic [15:0] bus_result_bits_r;
   logic [15:0] snap_r;
   logic phase_r;
   logic [7:0] wr_hi_r;
   logic [7:0] rd_byte_r;
   logic halt_r;
   logic start_pend_r;
   seq_state_type state_r;
   cyc_type timer_r;
   logic [NSAMP_W-1:0] nsamp_r;
   logic conv_done_r;
   logic wr_commit;
   logic [15:0] wr_word;
   logic [2:0] mode;
   logic [FIELD_W-1:0] sample_average_count;
   logic [FIELD_W-1:0] bus_conversion_time;
   logic [FIELD_W-1:0] shunt_conversion_time;
   logic seq_go;
   logic timer_end;
   logic last_sample;
   avg_link_if shunt_lnk ();
   avg_link_if bus_lnk ();

   assign mode = cfg_r[MODE_LSB +: FIELD_W];
   assign sample_average_count = cfg_r[AVG_LSB +: FIELD_W];
   assign bus_conversion_time = cfg_r[BUS_CT_LSB +: FIELD_W];
   assign shunt_conversion_time = cfg_r[SHUNT_CT_LSB +: FIELD_W];

   // ==========================================================
   // Reset
   // soft reset pulse
   // Soft reset takes effect one edge after the committing byte
   assign rst_all_b = rst_b && !soft_rst_r;
   always_ff @(posedge ref_clk) begin
      if (!rst_all_b) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= wr_commit && wr_hi_r[HI_BYTE_RST_BIT];
      end
   end

   // ==========================================================
   // Byte port
   function automatic logic [15:0] read_word(input logic [7:0] ptr);
      case (ptr)
         CFG_ADDR: read_word = cfg_r;
         SHUNT_ADDR: read_word = shunt_result_bits_r;
         BUS_ADDR: read_word = bus_result_bits_r;
         default: read_word = 16'h0000;
      endcase
   endfunction : read_word

   assign wr_word = {wr_hi_r, wr_byte};
   assign wr_commit = wr_stb && phase_r && reg_ptr == CFG_ADDR;

   // two bytes per word
   // Snapshot keeps the two bytes of one read coherent
   always_ff @(posedge ref_clk) begin
      if (!rst_all_b) begin
         phase_r <= 1'b0;
         wr_hi_r <= 8'h00;
         snap_r <= 16'h0000;
         rd_byte_r <= 8'h00;
      end else if (xfer_start) begin
         phase_r <= 1'b0;
         snap_r <= read_word(reg_ptr);
      end else if (wr_stb) begin
         phase_r <= !phase_r;
         if (!phase_r) begin
            wr_hi_r <= wr_byte;
         end
      end else if (rd_stb) begin
         phase_r <= !phase_r;
         rd_byte_r <= phase_r ? snap_r[7:0] : snap_r[15:8];
         if (phase_r) begin
            snap_r <= read_word(reg_ptr);
         end
      end
   end
   assign rd_byte = rd_byte_r;

   // ==========================================================
   // Configuration register
   always_ff @(posedge ref_clk) begin
      if (!rst_all_b) begin
         cfg_r <= CFG_RESET;
      end else if (wr_commit) begin
         cfg_r <= (wr_word & CFG_WR_MASK) | CFG_FIXED_VAL;
      end
   end

   // halt during write
   // A dropped transfer releases the halt and restarts old settings
   always_ff @(posedge ref_clk) begin
      if (!rst_all_b) begin
         halt_r <= 1'b0;
         start_pend_r <= 1'b1;
      end else if (wr_commit || (xfer_start && halt_r)) begin
         halt_r <= 1'b0;
         start_pend_r <= 1'b1;
      end else if (wr_stb && !phase_r && reg_ptr == CFG_ADDR) begin
         halt_r <= 1'b1;
      end else if (!halt_r) begin
         start_pend_r <= 1'b0;
      end
   end

   // ==========================================================
   // Conversion sequencer
   // power-down when no channel selected
   assign seq_go = (start_pend_r && !halt_r && !wr_commit &&
                    mode[1:0] != 2'b00) ||
                   (state_r == ST_DONE && mode[MODE_CONT_BIT] &&
                    mode[1:0] != 2'b00);
   assign timer_end = timer_r == cyc_type'(1);
   assign last_sample = nsamp_r ==
      NSAMP_W'((1 << avg_shift(sample_average_count)) - 1);

   always_ff @(posedge ref_clk) begin
      if (!rst_all_b) begin
         state_r <= ST_IDLE;
         timer_r <= '0;
         nsamp_r <= '0;
      end else if (halt_r || wr_commit) begin
         state_r <= ST_IDLE;
      end else if (seq_go) begin
         nsamp_r <= '0;
         if (mode[MODE_SHUNT_BIT]) begin
            state_r <= ST_SHUNT;
            timer_r <= CONV_CYC[shunt_conversion_time];
         end else begin
            state_r <= ST_BUS;
            timer_r <= CONV_CYC[bus_conversion_time];
         end
      end else begin
         case (state_r)
            ST_SHUNT: begin
               timer_r <= timer_r - cyc_type'(1);
               if (timer_end && mode[MODE_BUS_BIT]) begin
                  state_r <= ST_BUS;
                  timer_r <= CONV_CYC[bus_conversion_time];
               end else if (timer_end && last_sample) begin
                  state_r <= ST_DONE;
               end else if (timer_end) begin
                  nsamp_r <= nsamp_r + NSAMP_W'(1);
                  timer_r <= CONV_CYC[shunt_conversion_time];
               end
            end
            ST_BUS: begin
               timer_r <= timer_r - cyc_type'(1);
               if (timer_end && last_sample) begin
                  state_r <= ST_DONE;
               end else if (timer_end) begin
                  nsamp_r <= nsamp_r + NSAMP_W'(1);
                  if (mode[MODE_SHUNT_BIT]) begin
                     state_r <= ST_SHUNT;
                     timer_r <= CONV_CYC[shunt_conversion_time];
                  end else begin
                     timer_r <= CONV_CYC[bus_conversion_time];
                  end
               end
            end
            ST_DONE: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Averaging and results
   assign shunt_lnk.clear = seq_go;
   assign shunt_lnk.add = state_r == ST_SHUNT && timer_end && !halt_r;
   assign shunt_lnk.sample = shunt_drop_voltage;
   assign shunt_lnk.shift = avg_shift(sample_average_count);
   assign bus_lnk.clear = seq_go;
   assign bus_lnk.add = state_r == ST_BUS && timer_end && !halt_r;
   assign bus_lnk.sample = {1'b0, supply_rail_voltage};
   assign bus_lnk.shift = avg_shift(sample_average_count);

   sample_averager shunt_avg (
      .ref_clk(ref_clk),
      .rst_b(rst_all_b),
      .lnk(shunt_lnk.acc)
   );
   sample_averager bus_avg (
      .ref_clk(ref_clk),
      .rst_b(rst_all_b),
      .lnk(bus_lnk.acc)
   );

   // Results are taken in ST_DONE, one edge after the last add lands
   always_ff @(posedge ref_clk) begin
      if (!rst_all_b) begin
         shunt_result_bits_r <= RESULT_RESET;
         bus_result_bits_r <= RESULT_RESET;
         conv_done_r <= 1'b0;
      end else begin
         conv_done_r <= state_r == ST_DONE;
         if (state_r == ST_DONE && mode[MODE_SHUNT_BIT]) begin
            shunt_result_bits_r <= shunt_lnk.result;
         end
         if (state_r == ST_DONE && mode[MODE_BUS_BIT]) begin
            bus_result_bits_r <= bus_lnk.result & BUS_RESULT_MASK;
         end
      end
   end

   assign adc_active = state_r == ST_SHUNT || state_r == ST_BUS;
   assign adc_bus_sel = state_r == ST_BUS;
   assign conv_done = conv_done_r;
endmodule : shunt_bus_conversion_control
`default_nettype wire

/* verilog/shunt_bus_pkg.sv */
package shunt_bus_pkg;
   // ==========================================================
   // Register map and configuration layout
   localparam logic [7:0] CFG_ADDR = 8'h00;
   localparam logic [7:0] SHUNT_ADDR = 8'h01;
   localparam logic [7:0] BUS_ADDR = 8'h02;
   localparam logic [15:0] CFG_RESET = 16'h4127;
   localparam logic [15:0] CFG_WR_MASK = 16'h0fff;
   localparam logic [15:0] CFG_FIXED_VAL = 16'h4000;
   localparam logic [15:0] BUS_RESULT_MASK = 16'h7fff;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam int CFG_RST_BIT = 15;
   localparam int AVG_LSB = 9;
   localparam int BUS_CT_LSB = 6;
   localparam int SHUNT_CT_LSB = 3;
   localparam int MODE_LSB = 0;
   localparam int FIELD_W = 3;
   localparam int MODE_SHUNT_BIT = 0;
   localparam int MODE_BUS_BIT = 1;
   localparam int MODE_CONT_BIT = 2;
   localparam int HI_BYTE_RST_BIT = CFG_RST_BIT - 8;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int unsigned CONV_TIME_NS [8] = '{
      140000, 204000, 332000, 588000,
      1100000, 2116000, 4156000, 8244000};
   localparam int CYC_W = 22;
   typedef logic [CYC_W-1:0] cyc_type;
   localparam cyc_type CONV_CYC_TBL [8] = '{
      cyc_type'(CONV_TIME_NS[0] / CLK_PERIOD_NS),
      cyc_type'(CONV_TIME_NS[1] / CLK_PERIOD_NS),
      cyc_type'(CONV_TIME_NS[2] / CLK_PERIOD_NS),
      cyc_type'(CONV_TIME_NS[3] / CLK_PERIOD_NS),
      cyc_type'(CONV_TIME_NS[4] / CLK_PERIOD_NS),
      cyc_type'(CONV_TIME_NS[5] / CLK_PERIOD_NS),
      cyc_type'(CONV_TIME_NS[6] / CLK_PERIOD_NS),
      cyc_type'(CONV_TIME_NS[7] / CLK_PERIOD_NS)};

   // ==========================================================
   // Averaging
   localparam int SHIFT_W = 4;
   localparam int NSAMP_W = 11;
   localparam int ACC_W = 26;

   typedef enum {ST_IDLE, ST_SHUNT, ST_BUS, ST_DONE} seq_state_type;

   // Log2 of the sample count: 1,4,16,64,128,256,512,1024
   function automatic logic [SHIFT_W-1:0] avg_shift(
      input logic [FIELD_W-1:0] code);
      case (code)
         3'h0: avg_shift = 4'h0;
         3'h1: avg_shift = 4'h2;
         3'h2: avg_shift = 4'h4;
         3'h3: avg_shift = 4'h6;
         3'h4: avg_shift = 4'h7;
         3'h5: avg_shift = 4'h8;
         3'h6: avg_shift = 4'h9;
         default: avg_shift = 4'ha;
      endcase
   endfunction : avg_shift
endpackage : shunt_bus_pkg
